// File: logic/tsr_pkg.sv
// shared constants and types of the thermal sensor serial slave
// assumes a 125 MHz system clock and an external converter on the same clock
package tsr_pkg;
    // command byte codes selecting the registers
    localparam logic [7:0] CMD_TEMP = 8'h01;
    localparam logic [7:0] CMD_CONFIG = 8'h03;
    localparam logic [7:0] CMD_MFG = 8'hFE;
    localparam logic [7:0] CMD_DEVREV = 8'hFF;
    // reset values
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h80;
    // answer to a reserved command byte
    localparam logic [7:0] READ_FILL = 8'h00;
    // power_down_bit position inside configuration_control
    localparam int POWER_DOWN_BIT_POS = 6;
    // fixed upper four bits of the seven-bit slave address
    localparam logic [3:0] ADDR_UPPER = 4'h9;
    // failsafe result: +127 degrees
    localparam logic [7:0] TEMP_FAULT = 8'h7F;
    // bus timeout, figure in ms, count in cycles
    localparam int CLK_KHZ = 125000;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
    localparam int TCNT_W = 22;

    // serial slave states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RD_ACK, ST_IGNORE
    } tsr_bus_st_t;

    // result handed over by the converter
    typedef struct packed {
        logic done;
        logic fault;
        logic [7:0] data;
    } tsr_adc_res_t;

    // commands to the converter
    typedef struct packed {
        logic enable;
        logic start;
        logic abort;
    } tsr_adc_ctl_t;

    // state of the pin synchroniser
    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic lvl;
    } tsr_sync_st_t;

    // state of the slave and register set
    typedef struct packed {
        tsr_bus_st_t st;
        logic [3:0] bcnt;
        logic [7:0] shreg;
        logic [7:0] cmd;
        logic rw;
        logic drv;
        logic sda_o;
        logic scl_q;
        logic sda_q;
        logic [TCNT_W-1:0] tcnt;
        logic [7:0] configuration_control;
        logic [7:0] remote_temperature_result;
        logic busy;
        logic seen;
        logic start;
        logic abort;
        logic en;
    } tsr_state_t;
endpackage

// File: logic/tsr_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin and an already released reset
`timescale 1ns/1ps
module tsr_sync
    import tsr_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin and filtered level
    input wire logic pin,
    output logic level
);
    tsr_sync_st_t s; // registered state
    tsr_sync_st_t next_s; // next state

    // shift the pin in, accept a change once stage two and three agree
    always_comb begin
        next_s = s;
        next_s.f1 = pin;
        next_s.f2 = s.f1;
        next_s.f3 = s.f2;
        if (s.f2 == s.f3) begin
            next_s.lvl = s.f3;
        end
    end

    // register the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.lvl;
endmodule

// File: logic/tsr_top.sv
// two-wire serial slave and register set of the remote-diode thermal sensor
// assumes the host is the bus master and the converter shares clk_sys
`timescale 1ns/1ps

module tsr_top
    import tsr_pkg::*;
#(
    parameter logic [2:0] ADDR_SEL = 3'h0,
    parameter logic [7:0] MFG_CODE = 8'h5C, // arbitrary value
    parameter logic [3:0] DEV_CODE = 4'hB, // arbitrary value
    parameter logic [3:0] DIE_REV = 4'h0,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // serial bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // converter
    input wire tsr_adc_res_t adc_res,
    output tsr_adc_ctl_t adc_ctl
);
    logic [1:0] rst_q; // reset release chain
    logic rst_sync_n; // released reset
    logic scl_f; // filtered clock line
    logic sda_f; // filtered data line
    logic rise; // clock rising edge
    logic fall; // clock falling edge
    logic start_c; // start or repeated start
    logic stop_c; // stop condition
    logic tmo; // bus timeout reached
    logic cfg_wr; // configuration write this cycle
    tsr_state_t s; // registered state
    tsr_state_t next_s; // next state

    // read data selection by command byte
    function automatic logic [7:0] rd_mux(input logic [7:0] cmd, input logic [7:0] temp,
                                         input logic [7:0] cfg);
        case (cmd)
            CMD_TEMP: rd_mux = temp;
            CMD_CONFIG: rd_mux = cfg;
            CMD_MFG: rd_mux = MFG_CODE;
            CMD_DEVREV: rd_mux = {DEV_CODE, DIE_REV};
            default: rd_mux = READ_FILL;
        endcase
    endfunction

    // release reset through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    // pin synchronisers
    tsr_sync u_sync_scl (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .pin(scl),
        .level(scl_f)
    );
    tsr_sync u_sync_sda (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .pin(sda_in),
        .level(sda_f)
    );

    // line events from the filtered levels
    assign rise = scl_f & ~s.scl_q;
    assign fall = ~scl_f & s.scl_q;
    assign start_c = scl_f & s.scl_q & s.sda_q & ~sda_f;
    assign stop_c = scl_f & s.scl_q & ~s.sda_q & sda_f;
    assign tmo = (s.tcnt == TCNT_W'(TIMEOUT_CYCLES - 1));
    assign cfg_wr = (s.st == ST_WDATA) && fall && (s.bcnt == 4'h8) && (s.cmd == CMD_CONFIG);

    // serial slave, register set and conversion sequencer
    always_comb begin
        next_s = s;
        next_s.scl_q = scl_f;
        next_s.sda_q = sda_f;
        next_s.sda_o = 1'b0;
        next_s.start = 1'b0;
        next_s.abort = 1'b0;
        // count clock-low time inside a transfer
        if (s.st != ST_IDLE && !scl_f) begin
            next_s.tcnt = s.tcnt + TCNT_W'(1);
        end else begin
            next_s.tcnt = '0;
        end
        if (start_c) begin
            // start or repeated start: take an address
            next_s.st = ST_ADDR;
            next_s.bcnt = 4'h0;
            next_s.drv = 1'b0;
        end else if (stop_c || (s.st != ST_IDLE && tmo)) begin
            // stop or timeout: release the line
            next_s.st = ST_IDLE;
            next_s.drv = 1'b0;
            next_s.tcnt = '0;
        end else begin
            case (s.st)
                // receive a byte
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (rise) begin
                        next_s.shreg = {s.shreg[6:0], sda_f};
                        next_s.bcnt = s.bcnt + 4'h1;
                    end else if (fall && s.bcnt == 4'h8) begin
                        next_s.bcnt = 4'h0;
                        next_s.drv = 1'b1;
                        if (s.st == ST_ADDR) begin
                            if (s.shreg[7:1] == {ADDR_UPPER, ADDR_SEL}) begin
                                next_s.rw = s.shreg[0];
                                next_s.st = ST_ADDR_ACK;
                            end else begin
                                next_s.drv = 1'b0;
                                next_s.st = ST_IGNORE;
                            end
                        end else if (s.st == ST_CMD) begin
                            next_s.cmd = s.shreg;
                            next_s.st = ST_CMD_ACK;
                        end else begin
                            if (s.cmd == CMD_CONFIG) begin
                                next_s.configuration_control = s.shreg;
                            end
                            next_s.st = ST_WDATA_ACK;
                        end
                    end
                end
                // end of an acknowledge slot
                ST_ADDR_ACK: begin
                    if (fall) begin
                        if (s.rw) begin
                            next_s.shreg = rd_mux(s.cmd, s.remote_temperature_result,
                                                  s.configuration_control);
                            next_s.drv = ~next_s.shreg[7];
                            next_s.bcnt = 4'h1;
                            next_s.st = ST_RDATA;
                        end else begin
                            next_s.drv = 1'b0;
                            next_s.st = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    if (fall) begin
                        next_s.drv = 1'b0;
                        next_s.st = ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    if (fall) begin
                        next_s.drv = 1'b0;
                        next_s.st = ST_IGNORE;
                    end
                end
                // shift the read byte out, msb first
                ST_RDATA: begin
                    if (fall) begin
                        if (s.bcnt == 4'h8) begin
                            next_s.drv = 1'b0;
                            next_s.st = ST_RD_ACK;
                        end else begin
                            next_s.drv = ~s.shreg[6];
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                            next_s.bcnt = s.bcnt + 4'h1;
                        end
                    end
                end
                // master ack repeats the byte, nack ends it
                ST_RD_ACK: begin
                    if (rise) begin
                        next_s.st = sda_f ? ST_IGNORE : ST_ADDR_ACK;
                    end
                end
                default: begin
                    next_s.drv = 1'b0;
                end
            endcase
        end
        // conversion sequencer
        next_s.en = ~next_s.configuration_control[POWER_DOWN_BIT_POS];
        if (cfg_wr) begin
            next_s.busy = 1'b0;
            next_s.abort = 1'b1;
            if (next_s.configuration_control[POWER_DOWN_BIT_POS]) begin
                next_s.seen = 1'b0;
            end
        end else if (s.configuration_control[POWER_DOWN_BIT_POS]) begin
            next_s.busy = 1'b0;
            next_s.seen = 1'b0;
        end else if (!s.busy) begin
            next_s.start = 1'b1;
            next_s.busy = 1'b1;
        end else if (adc_res.done) begin
            next_s.busy = 1'b0;
            next_s.seen = 1'b1;
            next_s.remote_temperature_result = (adc_res.fault && s.seen) ?
                TEMP_FAULT : adc_res.data;
        end
    end

    // register the state
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '{st: ST_IDLE, bcnt: 4'h0, shreg: 8'h00, cmd: 8'h00, rw: 1'b0, drv: 1'b0,
                   sda_o: 1'b0, scl_q: 1'b1, sda_q: 1'b1, tcnt: '0,
                   configuration_control: CONFIG_RESET,
                   remote_temperature_result: TEMP_RESET, busy: 1'b0, seen: 1'b0,
                   start: 1'b0, abort: 1'b0, en: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = s.sda_o;
    assign sda_oe_n = ~s.drv;
    assign adc_ctl = '{enable: s.en, start: s.start, abort: s.abort};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n);

    AST_ADDR_MISS: assert property (
        (s.st == ST_ADDR && fall && s.bcnt == 4'h8 && s.shreg[7:1] != {ADDR_UPPER, ADDR_SEL})
        |=> (s.st == ST_IGNORE) && sda_oe_n
    ) else $error("foreign address was acknowledged");
    AST_CMD_LATCH: assert property (
        (s.st == ST_CMD && next_s.st == ST_CMD_ACK) |=> (s.cmd == $past(s.shreg)) && !sda_oe_n
    ) else $error("command byte not latched with ack");
    AST_CFG_WRITE: assert property (
        cfg_wr |=> (s.configuration_control == $past(s.shreg)) && s.abort
    ) else $error("configuration write lost");
    AST_RESTART: assert property (
        (s.abort && !s.configuration_control[POWER_DOWN_BIT_POS]) |=> s.start ##1 !s.start
    ) else $error("no restart after configuration write");
    AST_POWER_DOWN_BIT_STOP: assert property (
        s.configuration_control[POWER_DOWN_BIT_POS]
        |=> !s.start && (adc_ctl.enable == !s.configuration_control[POWER_DOWN_BIT_POS])
    ) else $error("converter active in shutdown");
    AST_POWER_DOWN_BIT_KEEP: assert property (
        s.configuration_control[POWER_DOWN_BIT_POS] [*2] |-> $stable(s.remote_temperature_result)
    ) else $error("result changed in shutdown");
    AST_FAULT: assert property (
        (s.busy && adc_res.done && adc_res.fault && s.seen && !cfg_wr
         && !s.configuration_control[POWER_DOWN_BIT_POS]) |=> s.remote_temperature_result == TEMP_FAULT
    ) else $error("fault not reported as full scale");
    AST_FIRST: assert property (
        (s.busy && adc_res.done && !s.seen && !cfg_wr && !s.configuration_control[POWER_DOWN_BIT_POS])
        |=> s.remote_temperature_result == $past(adc_res.data)
    ) else $error("first conversion result not stored");
    AST_TIMEOUT: assert property (
        (s.st != ST_IDLE && tmo && !start_c) |=> (s.st == ST_IDLE) && sda_oe_n
    ) else $error("bus timeout ignored");
    AST_READ_MSB: assert property (
        (s.st == ST_ADDR_ACK && s.rw && fall && !start_c && !stop_c && !tmo)
        |=> s.st == ST_RDATA && sda_oe_n ==
            $past(rd_mux(s.cmd, s.remote_temperature_result, s.configuration_control)) >> 7
    ) else $error("wrong first read bit");
endmodule

// File: bench/tsr_host.sv
// behavioural bus master that drives the serial clock and the data wire
// assumes a pull-up on the data wire; the bench calls its tasks
`timescale 1ns/1ps
module tsr_host
    import tsr_pkg::*;
#(
    parameter int PH = 16
) (
    // clock
    input wire logic clk_sys,
    // device pull-down on the data wire
    input wire logic sda_oe_n,
    // wire levels
    output logic scl,
    output logic sda_wire
);
    logic pull_low = 1'b0; // host holds data low
    // open-drain wire with pull-up
    assign sda_wire = !(pull_low || !sda_oe_n);
    initial scl = 1'b1;
    // wait n falling edges
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one bit slot; data moves mid-low, level sampled at the end of high
    task automatic bit_io(input logic b, output logic seen);
        hold(PH / 2);
        pull_low = !b;
        hold(PH / 2);
        scl = 1'b1;
        hold(PH);
        seen = sda_wire;
        scl = 1'b0;
    endtask
    // start, or repeated start when the clock is low
    task automatic start();
        if (!scl) begin
            hold(PH / 2);
            pull_low = 1'b0;
            hold(PH / 2);
            scl = 1'b1;
            hold(PH);
        end
        pull_low = 1'b1;
        hold(PH);
        scl = 1'b0;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        hold(PH / 2);
        pull_low = 1'b1;
        hold(PH / 2);
        scl = 1'b1;
        hold(PH);
        pull_low = 1'b0;
        hold(PH);
    endtask
    // byte out msb first, then the answer slot
    task automatic byte_w(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack_n);
    endtask
    // byte in msb first, then the host answer bit (low asks for more)
    task automatic byte_r(input logic ak_n, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(ak_n, s);
    endtask
    // address, command, data; k holds the three answer bits
    task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                             output logic [2:0] k);
        start();
        byte_w({a, 1'b0}, k[2]);
        byte_w(c, k[1]);
        byte_w(d, k[0]);
        stop();
    endtask
    // address, command, repeated start, address with read, byte back
    task automatic read_reg(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                            output logic [2:0] k);
        start();
        byte_w({a, 1'b0}, k[2]);
        byte_w(c, k[1]);
        start();
        byte_w({a, 1'b1}, k[0]);
        byte_r(1'b1, d);
        stop();
    endtask
    // read with a host ack after the first byte: the same byte comes twice
    task automatic read_two(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d0,
                            output logic [7:0] d1, output logic [2:0] k);
        start();
        byte_w({a, 1'b0}, k[2]);
        byte_w(c, k[1]);
        start();
        byte_w({a, 1'b1}, k[0]);
        byte_r(1'b0, d0);
        byte_r(1'b1, d1);
        stop();
    endtask
endmodule

// File: bench/tsr_top_tb.sv
// self-checking bench of the thermal sensor serial slave
// assumes the host model on the wire and a converter driven from here
`timescale 1ns/1ps
module tsr_top_tb
    import tsr_pkg::*;
;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [7:0] MFG = 8'h3C; // arbitrary value
    localparam logic [3:0] DEV = 4'h6; // arbitrary value
    localparam logic [3:0] REV = 4'h2;
    localparam int TO = 400; // shortened bus timeout
    localparam logic [6:0] ADR = {ADDR_UPPER, SEL};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic sda_wire;
    logic sda_out;
    logic sda_oe_n;
    tsr_adc_res_t adc_res = '0;
    tsr_adc_ctl_t adc_ctl;
    int err_total = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_abort = 0;
    logic [2:0] k;
    logic [7:0] d;
    logic [7:0] d2;
    always #4 clk_sys = ~clk_sys;
    tsr_top #(.ADDR_SEL(SEL), .MFG_CODE(MFG), .DEV_CODE(DEV), .DIE_REV(REV),
        .TIMEOUT_CYCLES(TO)) tsr_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .adc_res(adc_res),
        .adc_ctl(adc_ctl));
    tsr_host #(.PH(16)) tsr_host_i (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl),
        .sda_wire(sda_wire));
    // count converter command pulses
    always @(posedge clk_sys) begin
        n_start += int'(adc_ctl.start);
        n_abort += int'(adc_ctl.abort);
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // read a register and compare, answers included
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        tsr_host_i.read_reg(ADR, c, d, k);
        chk("read acks", {5'h00, k}, 8'h00);
        chk("read data", d, exp);
    endtask
    // converter finishes with the given flag and value
    task automatic done(input logic f, input logic [7:0] v);
        @(negedge clk_sys);
        adc_res = '{done: 1'b1, fault: f, data: v};
        @(negedge clk_sys);
        adc_res.done = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    // defaults, identifiers, reserved code, read-only write
    task automatic t_regs();
        logic [7:0] cmds[5] = '{CMD_TEMP, CMD_CONFIG, CMD_MFG, CMD_DEVREV, 8'h02};
        logic [7:0] exps[5] = '{TEMP_RESET, CONFIG_RESET, MFG, {DEV, REV}, READ_FILL};
        chk("enable", {7'h00, adc_ctl.enable}, 8'h01);
        chk("data out", {7'h00, sda_out}, 8'h00);
        tsr_host_i.write_reg(ADR, CMD_MFG, 8'h55, k);
        for (int i = 0; i < 5; i++) begin
            rd(cmds[i], exps[i]);
        end
    endtask
    // results, negative value, failsafe
    task automatic t_convert();
        done(1'b0, 8'hE7);
        rd(CMD_TEMP, 8'hE7);
        tsr_host_i.read_two(ADR, CMD_TEMP, d, d2, k);
        chk("repeat acks", {5'h00, k}, 8'h00);
        chk("repeat first", d, 8'hE7);
        chk("repeat second", d2, 8'hE7);
        done(1'b1, 8'h19);
        rd(CMD_TEMP, TEMP_FAULT);
    endtask
    // shutdown entry and exit
    task automatic t_shutdown();
        int s;
        s = n_abort;
        tsr_host_i.write_reg(ADR, CMD_CONFIG, 8'h40, k);
        chk("write acks", {5'h00, k}, 8'h00);
        chk("aborts", 8'(n_abort - s), 8'h01);
        chk("enable", {7'h00, adc_ctl.enable}, 8'h00);
        rd(CMD_CONFIG, 8'h40);
        done(1'b0, 8'h19);
        rd(CMD_TEMP, TEMP_FAULT);
        s = n_start;
        tsr_host_i.write_reg(ADR, CMD_CONFIG, 8'h00, k);
        chk("starts", 8'(n_start - s), 8'h01);
        chk("enable", {7'h00, adc_ctl.enable}, 8'h01);
        done(1'b1, 8'h19);
        rd(CMD_TEMP, 8'h19);
    endtask
    // another address is not answered
    task automatic t_addr();
        tsr_host_i.write_reg({ADDR_UPPER, ~SEL}, CMD_CONFIG, 8'h40, k);
        chk("foreign acks", {5'h00, k}, 8'h07);
        rd(CMD_CONFIG, 8'h00);
    endtask
    // clock held low during the answer slot
    task automatic t_timeout();
        logic s;
        tsr_host_i.start();
        for (int i = 6; i >= 0; i--) begin
            tsr_host_i.bit_io(ADR[i], s);
        end
        tsr_host_i.bit_io(1'b0, s);
        repeat (20) @(negedge clk_sys);
        chk("ack held", {7'h00, sda_oe_n}, 8'h00);
        repeat (TO + 20) @(negedge clk_sys);
        chk("released", {7'h00, sda_oe_n}, 8'h01);
        tsr_host_i.stop();
        rd(CMD_TEMP, 8'h19);
    endtask
    // watchdog on the whole run
    initial begin
        repeat (80000) @(posedge clk_sys);
        err_total++;
        $display("CHECK FAILED watchdog expected end seen hang");
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_regs();
        t_convert();
        t_shutdown();
        t_addr();
        t_timeout();
        print_verdict();
    end
endmodule
